// [test/tci_host_model.sv]
module tci_host_model (
    input  wire logic sys_clk,   // Paces the link edges
    output logic      ser_clk,   // Shift clock, idle low between frames except for junk clocks
    output logic      ser_data,  // Serial data
    output logic      ser_latch  // Latch enable, idle high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b1;
    end
    // Half of the 160 ns link period
    task automatic pace();
        repeat (10) @(posedge sys_clk);
    endtask : pace
    // Junk clocks toggle data while the latch is still high
    task automatic frame(input logic [22:0] w, input int n, input int junk);
        repeat (junk) begin
            ser_data <= ~ser_data;
            pace();
            ser_clk <= 1'b1;
            pace();
            ser_clk <= 1'b0;
        end
        ser_latch <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            ser_data <= w[i];
            pace();
            ser_clk <= 1'b1;
            pace();
            ser_clk <= 1'b0;
        end
        ser_data <= ~ser_data;  // Released data must not look held
        pace();
        ser_latch <= 1'b1;
        // Latch stays high well past its minimum pulse width
        repeat (3) pace();
    endtask : frame
    task automatic send_freq(input logic [22:0] w);
        frame(w, 23, 0);
    endtask : send_freq
    task automatic send_cfg(input logic [11:0] w, input int junk);
        frame({11'h000, w}, 12, junk);
    endtask : send_cfg
endmodule : tci_host_model

// [test/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tci_pkg::*;
    logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err, strap;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ser_clk, ser_data, ser_latch, chip_active_select, receive_select;
    logic        synth_locked, slicer_bit, recovered_clk_raw, slicer_time_select_i;
    logic        slicer_time_select_o, slicer_time_select_oe, slicer_fast_tc;
    logic        tr_switch_positive, tr_switch_negative, pa_enable, rx_data_out, cal_start;
    tci_mode_t   mode;
    int          errors, checks, ncal;
    // Device drive wins on the shared pin, else the board strap
    assign slicer_time_select_i = slicer_time_select_oe ? slicer_time_select_o : strap;
    tci_transceiver_ctl #(.CAL_INTERVAL_CYCLES(200)) DUT (
        .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .ser_clk, .ser_data, .ser_latch, .chip_active_select, .receive_select,
        .synth_locked, .slicer_bit, .recovered_clk_raw, .slicer_time_select_i,
        .slicer_time_select_o, .slicer_time_select_oe, .slicer_fast_tc, .tr_switch_positive,
        .tr_switch_negative, .pa_enable, .rx_data_out, .cal_start, .mode
    );
    tci_host_model host (.sys_clk, .ser_clk, .ser_data, .ser_latch);
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        recovered_clk_raw <= ~recovered_clk_raw;
        if (cal_start === 1'b1)
            ncal <= ncal + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
        check("pslverr", 32'(err), 32'(exp_err));
    endtask : rd_chk
    // Raw recovered clock toggles every cycle, so any leak shows here
    task automatic neg_high(input string what);
        repeat (8) begin
            check(what, 32'(tr_switch_negative), 32'h1);
            tick(3);
        end
    endtask : neg_high
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        final_report();
    end
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        chip_active_select = 1'b0;
        receive_select = 1'b1;
        synth_locked = 1'b0;
        slicer_bit = 1'b0;
        recovered_clk_raw = 1'b0;
        strap = 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        tick(3);
        check("mode", 32'(mode), 32'(TCI_STANDBY));
        rd_chk("ctrl", ADDR_CTRL, 32'(CTRL_RESET), 1'b0);
        rd_chk("unmapped", 8'h10, 32'h0, 1'b1);
        host.send_freq(23'h2B3C4D);
        host.send_cfg(12'h022, 0);
        rd_chk("freq", ADDR_FREQ, 32'h002B3C4D, 1'b0);
        rd_chk("cfg", ADDR_CFG, 32'h00000022, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h00000040);
        rd_chk("ctrl", ADDR_CTRL, 32'h00000040, 1'b0);
        check("lock_oe", 32'(slicer_time_select_oe), 32'h1);
        check("lock_pin", 32'(slicer_time_select_o), 32'h0);
        synth_locked <= 1'b1;
        chip_active_select <= 1'b1;
        slicer_bit <= 1'b1;
        tick(6);
        check("lock_pin", 32'(slicer_time_select_o), 32'h1);
        check("mode", 32'(mode), 32'(TCI_RECEIVE));
        check("rx_data", 32'(rx_data_out), 32'h1);
        check("sw_pos", 32'(tr_switch_positive), 32'h0);
        rd = 32'(tr_switch_negative);
        tick(1);
        check("rclk_pin", 32'(tr_switch_negative), ~rd & 32'h1);
        tick(32200);
        check("cal_many", 32'(ncal > 100), 32'h1);
        slicer_bit <= 1'b0;
        tick(6);
        check("rx_data", 32'(rx_data_out), 32'h0);
        chip_active_select <= 1'b0;
        tick(100);
        rd = 32'(tr_switch_negative);
        tick(1);
        check("rclk_tail", 32'(tr_switch_negative), ~rd & 32'h1);
        tick(909);
        neg_high("tail_end");
        check("mode", 32'(mode), 32'(TCI_STANDBY));
        host.send_cfg(12'h004, 0);
        check("sel_oe", 32'(slicer_time_select_oe), 32'h0);
        host.send_cfg(12'h005, 11);
        rd_chk("cfg", ADDR_CFG, 32'h00000005, 1'b0);
        rd_chk("freq", ADDR_FREQ, 32'h002B3C4D, 1'b0);
        check("sel_oe", 32'(slicer_time_select_oe), 32'h0);
        strap <= 1'b1;
        tick(4);
        check("fast_tc", 32'(slicer_fast_tc), 32'h1);
        strap <= 1'b0;
        tick(4);
        check("fast_tc", 32'(slicer_fast_tc), 32'h0);
        chip_active_select <= 1'b1;
        tick(6);
        neg_high("no_rclk");
        synth_locked <= 1'b0;
        receive_select <= 1'b0;
        tick(6);
        check("mode", 32'(mode), 32'(TCI_TRANSMIT));
        check("pa", 32'(pa_enable), 32'h0);
        check("sw_pos", 32'(tr_switch_positive), 32'h0);
        check("sw_neg", 32'(tr_switch_negative), 32'h1);
        synth_locked <= 1'b1;
        tick(6);
        check("pa", 32'(pa_enable), 32'h1);
        check("sw_pos", 32'(tr_switch_positive), 32'h1);
        check("sw_neg", 32'(tr_switch_negative), 32'h0);
        host.send_freq(23'h7FFFFF);
        rd_chk("freq", ADDR_FREQ, 32'h007FFFFF, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h00000042);
        receive_select <= 1'b1;
        tick(60);
        check("sw_pos", 32'(tr_switch_positive), 32'h0);
        receive_select <= 1'b0;
        tick(20);
        check("sw_pos", 32'(tr_switch_positive), 32'h0);
        tick(30);
        check("sw_pos", 32'(tr_switch_positive), 32'h1);
        chip_active_select <= 1'b0;
        tick(6);
        check("mode", 32'(mode), 32'(TCI_STANDBY));
        final_report();
    end
endmodule : testbench

// [verilog/tci_pkg.sv]
package tci_pkg;
    localparam int          CLK_MHZ            = 125;
    localparam int          RECOVERED_BIT_CLOCK_TAIL_US      = 6;
    localparam int          RECOVERED_BIT_CLOCK_TAIL_CYCLES  = RECOVERED_BIT_CLOCK_TAIL_US * CLK_MHZ;
    localparam int          CAL_INTERVAL_DFLT  = 1000000;
    localparam int          SW_DELAY_UNIT      = 16;
    localparam int          FREQ_WORD_BITS     = 23;
    localparam int          CFG_WORD_BITS      = 12;
    localparam logic [7:0]  ADDR_CTRL          = 8'h00;
    localparam logic [7:0]  ADDR_STATUS        = 8'h04;
    localparam logic [7:0]  ADDR_FREQ          = 8'h08;
    localparam logic [7:0]  ADDR_CFG           = 8'h0C;
    localparam logic [6:0]  CTRL_RESET         = 7'h00;
    localparam logic [2:0]  SLICER_PIN_IN_A    = 3'h4;
    localparam logic [2:0]  SLICER_PIN_IN_B    = 3'h5;
    localparam logic [2:0]  RATE_576K          = 3'h0;
    localparam logic [2:0]  RATE_2048K         = 3'h4;

    typedef enum logic [2:0] {
        TCI_STANDBY  = 3'b001,
        TCI_RECEIVE  = 3'b010,
        TCI_TRANSMIT = 3'b100
    } tci_mode_t;

    // Config word carried by any nonempty serial word that is not 23 bits long
    typedef struct packed {
        logic [5:0] spare;
        logic [2:0] rate;
        logic [2:0] slicer_mode_field;
    } tci_cfg_t;

    // Software control word
    typedef struct packed {
        logic       recover_clk_en;
        logic [5:0] sw_delay;
    } tci_ctrl_t;
endpackage : tci_pkg

// [verilog/tci_transceiver_ctl.sv]
module tci_transceiver_ctl
    import tci_pkg::*;
#(
    parameter int CAL_INTERVAL_CYCLES = CAL_INTERVAL_DFLT
) (
    input  wire logic        sys_clk,               // System clock, 125 MHz
    input  wire logic        resetn,                // Synchronous reset
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB access phase
    input  wire logic        pwrite,                // APB direction
    input  wire logic [7:0]  paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic             pready,                // APB ready
    output logic [31:0]      prdata,                // APB read data
    output logic             pslverr,               // APB error
    input  wire logic        ser_clk,               // Serial shift clock pin
    input  wire logic        ser_data,              // Serial data pin
    input  wire logic        ser_latch,             // Serial latch enable pin
    input  wire logic        chip_active_select,    // Chip enable pin
    input  wire logic        receive_select,        // Receive/transmit pin
    input  wire logic        synth_locked,          // Lock detector level
    input  wire logic        slicer_bit,            // Sliced demodulator bit
    input  wire logic        recovered_clk_raw,     // Clock recovery circuit output
    input  wire logic        slicer_time_select_i,  // Shared pin input
    output logic             slicer_time_select_o,  // Shared pin output
    output logic             slicer_time_select_oe, // Shared pin drive enable
    output logic             slicer_fast_tc,        // 1: 6 us, 0: 300 us slicer
    output logic             tr_switch_positive,    // Positive switch pin
    output logic             tr_switch_negative,    // Negative switch / bit clock
    output logic             pa_enable,             // Power amplifier enable
    output logic             rx_data_out,           // Digital receive output
    output logic             cal_start,             // Calibration trigger pulse
    output tci_mode_t        mode                   // Operating mode
);
    // Everything from a pin passes two flops; only the second stage is read
    logic [7:0] sync1, sync2, next_sync1, next_sync2;
    logic       sclk_d, en_d, next_sclk_d, next_en_d;
    logic       s_sclk, s_data, s_en, s_cas, s_rxs, s_lock, s_slice, s_rclk;
    logic       shift_evt, latch_evt;
    // The shared pin is a board strap, but it still crosses into this domain
    logic       sel_sync1, sel_sync2, next_sel_sync1, next_sel_sync2;

    always_comb begin
        next_sync1  = {recovered_clk_raw, slicer_bit, synth_locked, receive_select,
                       chip_active_select, ser_latch, ser_data, ser_clk};
        next_sync2  = sync1;
        next_sclk_d = s_sclk;
        next_en_d   = s_en;
        next_sel_sync1 = slicer_time_select_i;
        next_sel_sync2 = sel_sync1;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            // Latch enable idles high; a low reset here would fake a load edge
            sync1     <= 8'h04;
            sync2     <= 8'h04;
            sclk_d    <= 1'b0;
            en_d      <= 1'b1;
            sel_sync1 <= 1'b0;
            sel_sync2 <= 1'b0;
        end else begin
            sync1     <= next_sync1;
            sync2     <= next_sync2;
            sclk_d    <= next_sclk_d;
            en_d      <= next_en_d;
            sel_sync1 <= next_sel_sync1;
            sel_sync2 <= next_sel_sync2;
        end
    end

    assign {s_rclk, s_slice, s_lock, s_rxs, s_cas, s_en, s_data, s_sclk} = sync2;
    assign shift_evt = s_sclk && !sclk_d && !s_en;
    assign latch_evt = s_en && !en_d;

    // Serial shifter and loaded words
    logic [31:0] shreg, next_shreg;
    logic [5:0]  bit_cnt, next_bit_cnt;
    logic [22:0] freq_word, next_freq_word;
    tci_cfg_t    cfg, next_cfg;
    logic        freq_load, next_freq_load;

    always_comb begin
        next_shreg     = shreg;
        next_bit_cnt   = bit_cnt;
        next_freq_word = freq_word;
        next_cfg       = cfg;
        next_freq_load = 1'b0;
        if (latch_evt) begin
            // The word is whatever arrived since the last latch, oldest bit highest
            next_bit_cnt = 6'h00;
            if (bit_cnt == 6'(FREQ_WORD_BITS)) begin
                next_freq_word = shreg[22:0];
                next_freq_load = 1'b1;
            end else if (bit_cnt != 6'h00) begin
                next_cfg = tci_cfg_t'(shreg[CFG_WORD_BITS-1:0]);
            end
        end else if (shift_evt) begin
            next_shreg = {shreg[30:0], s_data};
            if (bit_cnt != 6'h20) begin
                next_bit_cnt = bit_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            shreg     <= 32'h0000_0000;
            bit_cnt   <= 6'h00;
            freq_word <= 23'h00_0000;
            cfg       <= tci_cfg_t'(12'h000);
            freq_load <= 1'b0;
        end else begin
            shreg     <= next_shreg;
            bit_cnt   <= next_bit_cnt;
            freq_word <= next_freq_word;
            cfg       <= next_cfg;
            freq_load <= next_freq_load;
        end
    end

    // Mode, switches, clock tail and calibration
    tci_ctrl_t  ctrl, next_ctrl;
    tci_mode_t  next_mode;
    logic       tx_sw, next_tx_sw;
    logic [9:0] dly_cnt, next_dly_cnt;
    logic [9:0] tail_cnt, next_tail_cnt;
    logic [31:0] cal_cnt, next_cal_cnt;
    logic       cal_done, next_cal_done, next_cal_start;
    logic       next_rx_data, pin_is_input, rclk_allowed, rclk_mode;

    assign pin_is_input = (cfg.slicer_mode_field == SLICER_PIN_IN_A) ||
                          (cfg.slicer_mode_field == SLICER_PIN_IN_B);
    assign rclk_allowed = (cfg.rate != RATE_576K) && (cfg.rate <= RATE_2048K);
    assign rclk_mode    = ctrl.recover_clk_en && rclk_allowed;

    always_comb begin
        next_mode = TCI_STANDBY;
        if (s_cas) begin
            next_mode = s_rxs ? TCI_RECEIVE : TCI_TRANSMIT;
        end
        // Switch state follows the mode after the programmed delay
        next_tx_sw   = tx_sw;
        next_dly_cnt = dly_cnt;
        if ((mode == TCI_TRANSMIT) == tx_sw) begin
            next_dly_cnt = 10'(ctrl.sw_delay) * 10'(SW_DELAY_UNIT);
        end else if (dly_cnt != 10'h000) begin
            next_dly_cnt = dly_cnt - 10'h001;
        end else begin
            next_tx_sw = (mode == TCI_TRANSMIT);
        end
        next_tail_cnt = tail_cnt;
        if (mode == TCI_RECEIVE) begin
            next_tail_cnt = 10'(RECOVERED_BIT_CLOCK_TAIL_CYCLES);
        end else if (tail_cnt != 10'h000) begin
            next_tail_cnt = tail_cnt - 10'h001;
        end
        next_cal_start = 1'b0;
        next_cal_done  = cal_done;
        next_cal_cnt   = cal_cnt;
        if (mode == TCI_STANDBY) begin
            next_cal_cnt = 32'h0000_0000;
        end else if (!cal_done || cal_cnt == 32'(CAL_INTERVAL_CYCLES - 1)) begin
            // Only a trigger; the analog loop absorbs it in the lock time
            next_cal_start = 1'b1;
            next_cal_done  = 1'b1;
            next_cal_cnt   = 32'h0000_0000;
        end else begin
            next_cal_cnt = cal_cnt + 32'h0000_0001;
            next_cal_start = freq_load || (next_mode == TCI_RECEIVE && mode != TCI_RECEIVE);
        end
        next_rx_data = (mode == TCI_RECEIVE) ? s_slice : 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode        <= TCI_STANDBY;
            tx_sw       <= 1'b0;
            dly_cnt     <= 10'h000;
            tail_cnt    <= 10'h000;
            cal_cnt     <= 32'h0000_0000;
            cal_done    <= 1'b0;
            cal_start   <= 1'b0;
            rx_data_out <= 1'b0;
        end else begin
            mode        <= next_mode;
            tx_sw       <= next_tx_sw;
            dly_cnt     <= next_dly_cnt;
            tail_cnt    <= next_tail_cnt;
            cal_cnt     <= next_cal_cnt;
            cal_done    <= next_cal_done;
            cal_start   <= next_cal_start;
            rx_data_out <= next_rx_data;
        end
    end

    // Pin drivers; an unlocked synthesizer parks the PA and positive switch inactive
    assign pa_enable             = (mode == TCI_TRANSMIT) && s_lock;
    assign tr_switch_positive    = tx_sw && s_lock && (mode == TCI_TRANSMIT);
    assign slicer_time_select_oe = !pin_is_input;
    assign slicer_time_select_o  = pin_is_input ? 1'b0 : s_lock;
    assign slicer_fast_tc        = pin_is_input && sel_sync2;
    always_comb begin
        if (rclk_mode) begin
            tr_switch_negative = (mode == TCI_RECEIVE || tail_cnt != 10'h000) ? s_rclk : 1'b1;
        end else begin
            tr_switch_negative = !(tx_sw && s_lock && mode == TCI_TRANSMIT);
        end
    end

    // APB slave: zero wait states, read data captured in the setup cycle
    logic [31:0] next_prdata;
    logic        next_pslverr, addr_ok;
    assign pready  = 1'b1;
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_FREQ) || (paddr == ADDR_CFG);

    always_comb begin
        next_ctrl    = ctrl;
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (psel && !penable) begin
            next_pslverr = !addr_ok;
            case (paddr)
                ADDR_CTRL:   next_prdata = {25'h000_0000, ctrl};
                ADDR_STATUS: next_prdata = {20'h0_0000, bit_cnt, tx_sw, s_lock, cal_done, mode};
                ADDR_FREQ:   next_prdata = {9'h000, freq_word};
                ADDR_CFG:    next_prdata = {20'h0_0000, cfg};
                default:     next_prdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            next_ctrl = tci_ctrl_t'(pwdata[6:0]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl    <= tci_ctrl_t'(CTRL_RESET);
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence latch_rise;
        latch_evt && bit_cnt == 6'(FREQ_WORD_BITS);
    endsequence

    a_latch_loads: assert property (latch_rise |=> freq_word == $past(shreg[22:0]) && bit_cnt == 6'h00)
        else $error("Frequency word not loaded on latch rise");
    a_no_shift_high: assert property (s_en && !latch_evt |=> $stable(shreg))
        else $error("Shifted while latch enable high");
    a_shift_bit: assert property (shift_evt && !latch_evt |=> shreg[0] == $past(s_data) && shreg[31:1] == $past(shreg[30:0]))
        else $error("Bit not shifted on clock rise");
    a_pin_input: assert property (pin_is_input |-> !slicer_time_select_oe &&
        slicer_fast_tc == $past(slicer_time_select_i, 2))
        else $error("Shared pin not an input in slicer modes");
    a_lock_flag: assert property (!pin_is_input |-> slicer_time_select_oe && slicer_time_select_o == s_lock)
        else $error("Lock flag not driven");
    a_standby_mode: assert property (!s_cas |=> mode == TCI_STANDBY)
        else $error("Not in standby with chip select low");
    a_mode_select: assert property (s_cas |=> mode == ($past(s_rxs) ? TCI_RECEIVE : TCI_TRANSMIT))
        else $error("Wrong active mode");
    a_rx_idle: assert property (mode != TCI_RECEIVE |=> !rx_data_out)
        else $error("Receive output active outside receive");
    a_pa_gated: assert property (!s_lock |-> !pa_enable && !tr_switch_positive)
        else $error("Power amplifier or switch on while unlocked");
    a_neg_switch: assert property (!rclk_mode && tr_switch_positive |-> !tr_switch_negative)
        else $error("Switch outputs not complementary");
    a_clk_settles: assert property (rclk_mode && mode != TCI_RECEIVE && tail_cnt == 10'h000 |-> tr_switch_negative)
        else $error("Bit clock pin not high after tail");
    a_cal_first: assert property (mode != TCI_STANDBY && !cal_done |=> cal_start ##1 !cal_start || freq_load)
        else $error("First calibration not triggered");
endmodule : tci_transceiver_ctl
